// ### tb/boot_strap_reset_config_monitor.sv
`timescale 1ns/1ps
module boot_strap_reset_config_monitor
  import boot_strap_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Watched ports
  input wire logic [STRAP_PIN_WIDTH-1:0] async_address_pins,
  input wire logic async_pin_function,
  input wire logic [3:0] async_pin_arrangement,
  input wire logic core_reset_hold,
  input wire logic fetch_valid,
  input wire logic fetch_override,
  input wire logic [31:0] boot_vector,
  input wire logic [1:0] boot_select,
  input wire logic [3:0] async_pin_config_strap,
  input wire logic [NUM_MODULES-1:0] module_enable,
  input wire logic timing_write,
  input wire wait_timing_s timing_in,
  input wire wait_timing_s async_timing
);
  wire [5:0] pin_straps = async_address_pins[13:8];
  wire run = !core_reset_hold;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_strap_capture: assert property (
    $rose(async_pin_function) |-> {boot_select, async_pin_config_strap} == $past(pin_straps)) else $error("strap capture");
  a_strap_hold: assert property (
    async_pin_function && $past(async_pin_function) |-> $stable(async_pin_config_strap) && $stable(boot_select))
    else $error("straps moved");
  a_pin_return: assert property (
    run |-> async_pin_function) else $error("pins not returned");
  a_rom_vector: assert property (
    async_pin_function && boot_select != 2'h1 |-> boot_vector == ROM_START_ADDR) else $error("rom vector");
  a_async_vector: assert property (
    async_pin_function && boot_select == 2'h1 |-> boot_vector == ASYNC_START_ADDR) else $error("async vector");
  a_single_override: assert property (
    fetch_valid && fetch_override |=> !fetch_override [*8]) else $error("override repeats");
  a_async_enable: assert property (
    run |-> module_enable[MOD_ASYNC_IF] == (boot_select != 2'h2)) else $error("async if state");
  a_card_enable: assert property (
    run |-> module_enable[MOD_CARD_IF_0] == (boot_select == 2'h2)) else $error("card state");
  a_uart_enable: assert property (
    run |-> module_enable[MOD_UART_0] == (boot_select == 2'h3)) else $error("uart state");
  a_spi_enable: assert property (
    run |-> module_enable[MOD_SPI_0] == (boot_select != 2'h1)) else $error("spi state");
  a_timing_load: assert property (
    timing_write && run && module_enable[MOD_ASYNC_IF] |=> async_timing == $past(timing_in)) else $error("timing load");
  a_timing_idle: assert property (
    !module_enable[MOD_ASYNC_IF] |-> async_timing == WAIT_RESET) else $error("timing not slowest");
  a_pin_arrange: assert property (
    $rose(async_pin_function) |-> async_pin_arrangement == $past(pin_straps[3:0])) else $error("pin arrangement");
endmodule
bind boot_strap_reset_config boot_strap_reset_config_monitor u_mon (.clock, .reset, .async_address_pins,
  .async_pin_function, .async_pin_arrangement, .core_reset_hold, .fetch_valid, .fetch_override, .boot_vector,
  .boot_select, .async_pin_config_strap, .module_enable, .timing_write, .timing_in, .async_timing);

// ### tb/boot_strap_reset_config_tb.sv
`timescale 1ns/1ps
module boot_strap_reset_config_tb;
  import boot_strap_pkg::*;
  logic clock = 0;
  logic reset = 1;
  logic [5:0] strap = '0;
  logic [3:0] fdly = '0;
  logic timing_write = 0;
  wait_timing_s timing_in = WAIT_RESET;
  logic [13:0] pins;
  // Jump template handed to the design, value arbitrary
  localparam logic [31:0] JT = 32'h5500_0000;
  logic fv, pin_fn, hold, ovr, rom, dexec, cs0b;
  logic [3:0] arr, cfg;
  logic [31:0] vec, bcr, jump, tgt;
  logic [1:0] sel, s;
  logic [40:0] en, srst, pwr, exp_en, pwr_exp;
  wait_timing_s tmg;
  int n_fail = 0;
  int n_compared = 0;
  always #5 clock = ~clock;
  strap_core_model u_model (.clock, .strap, .fetch_delay(fdly), .pin_function(pin_fn), .core_hold(hold),
    .pins, .fetch_valid(fv));
  boot_strap_reset_config #(.JUMP_TEMPLATE(JT)) u_dut (.clock, .reset, .async_address_pins(pins),
    .async_pin_function(pin_fn),
    .async_pin_arrangement(arr), .core_reset_hold(hold), .fetch_valid(fv), .fetch_override(ovr),
    .fetch_override_word(jump), .boot_vector(vec), .boot_select(sel), .async_pin_config_strap(cfg),
    .boot_config_reg(bcr), .rom_boot(rom), .direct_async_exec(dexec), .async_chip_select_0_boot(cs0b),
    .module_enable(en), .sync_reset_state(srst), .power_domain_on(pwr), .timing_write, .timing_in,
    .async_timing(tmg));
  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Bounded wait on override (0) or fetch strobe (1)
  task automatic await(input bit which);
    repeat (20)
    begin
      if ((which ? fv : ovr) === 1'b1)
        return;
      @(posedge clock);
      #1;
    end
    n_fail++;
    finish_test();
  endtask
  initial
  begin
    void'($urandom(91861));
    for (int k = 0; k < 8; k++)
    begin
      s = 2'(k);
      strap = {s, 4'($urandom)};
      fdly = 4'($urandom);
      reset = 1;
      repeat (10) @(posedge clock);
      #1 reset = 0;
      pwr_exp = '1;
      pwr_exp[MOD_RESERVED_A] = 0;
      pwr_exp[MOD_RESERVED_B] = 0;
      exp_en = '0;
      exp_en[MOD_FIXED_ON_HI:MOD_FIXED_ON_LO] = '1;
      exp_en[MOD_TIMER_0] = 1;
      exp_en[MOD_EDMA_TC1:MOD_EDMA_CC] = {3{s != 2'h2}};
      exp_en[MOD_ASYNC_IF] = (s != 2'h2);
      exp_en[MOD_CARD_IF_0] = (s == 2'h2);
      exp_en[MOD_UART_0] = (s == 2'h3);
      exp_en[MOD_SPI_0] = (s != 2'h1);
      await(0);
      chk("hold", 0, hold);
      chk("boot_select", s, sel);
      chk("pin_config", strap[3:0], cfg);
      chk("arrangement", strap[3:0], arr);
      chk("pin_function", 1, pin_fn);
      chk("vector", s == 2'h1 ? ASYNC_START_ADDR : ROM_START_ADDR, vec);
      chk("config_reg", {23'h0, s != 2'h1, strap[3:0], 2'h0, s}, bcr);
      chk("rom_boot", s != 2'h1, rom);
      chk("direct_exec", s == 2'h1, dexec);
      tgt = (s == 2'h1) ? ASYNC_START_ADDR : ROM_START_ADDR;
      chk("jump_word", {JT[31:24], tgt[25:2]}, jump);
      chk("cs0_boot", s == 2'h1, cs0b);
      chk("enable", exp_en, en);
      chk("sync_reset", ~exp_en & pwr_exp, srst);
      chk("power", pwr_exp, pwr);
      chk("timing", WAIT_RESET, tmg);
      await(1);
      @(posedge clock);
      #1;
      chk("override", 0, ovr);
      timing_write = 1;
      timing_in = 21'($urandom);
      @(posedge clock);
      #1;
      timing_write = 0;
      chk("timing_write", s == 2'h2 ? WAIT_RESET : timing_in, tmg);
    end
    finish_test();
  end
endmodule

// ### tb/strap_core_model.sv
`timescale 1ns/1ps
module strap_core_model
  import boot_strap_pkg::*;
(
  // Board straps and core
  input wire logic clock,
  input wire logic [5:0] strap,
  input wire logic [3:0] fetch_delay,
  input wire logic pin_function,
  input wire logic core_hold,
  output logic [STRAP_PIN_WIDTH-1:0] pins = '0,
  output logic fetch_valid = 1'b0
);
  int cnt = 0;
  always @(posedge clock)
  begin
    // Then live address traffic, so late capture shows
    pins <= pin_function ? 14'($urandom) : {strap, 8'($urandom)};
    cnt <= core_hold ? 0 : cnt + 1;
    // First fetch strobe when the count since hold release hits fetch_delay + 1
    fetch_valid <= (cnt == fetch_delay + 1);
  end
endmodule

// ### verilog/boot_strap_pkg.sv
package boot_strap_pkg;

  // Module slots handed to the power controller
  localparam int NUM_MODULES = 41;
  localparam int MOD_EDMA_CC = 2;
  localparam int MOD_EDMA_TC0 = 3;
  localparam int MOD_EDMA_TC1 = 4;
  localparam int MOD_ASYNC_IF = 14;
  localparam int MOD_CARD_IF_0 = 15;
  localparam int MOD_RESERVED_A = 16;
  localparam int MOD_UART_0 = 19;
  localparam int MOD_SPI_0 = 22;
  localparam int MOD_TIMER_0 = 27;
  localparam int MOD_FIXED_ON_LO = 29;
  localparam int MOD_FIXED_ON_HI = 38;
  localparam int MOD_RESERVED_B = 39;

  // Strap pin positions on the async address pins
  localparam int STRAP_PIN_WIDTH = 14;
  localparam int BOOT_SEL_LSB = 12;
  localparam int PIN_CFG_LSB = 8;

  // Boot select encodings
  localparam logic [1:0] BOOT_ROM_NAND = 2'h0;
  localparam logic [1:0] BOOT_ASYNC_MEM = 2'h1;
  localparam logic [1:0] BOOT_ROM_CARD = 2'h2;
  localparam logic [1:0] BOOT_ROM_UART = 2'h3;

  // Values the internal pulls give the straps
  localparam logic [1:0] BOOT_SEL_PULL_DEFAULT = 2'h0;
  localparam logic [3:0] PIN_CFG_PULL_DEFAULT = 4'hd;

  // Jump targets forced into the first fetch
  localparam logic [31:0] ROM_START_ADDR = 32'h0000_8000;
  localparam logic [31:0] ASYNC_START_ADDR = 32'h0200_0000;

  // Slowest wait-state set, in clock cycles
  localparam int TIMING_WIDTH = 7;
  localparam logic [6:0] WAIT_SETUP_RESET = 7'h10;
  localparam logic [6:0] WAIT_STROBE_RESET = 7'h40;
  localparam logic [6:0] WAIT_HOLD_RESET = 7'h08;

  // Boot configuration word layout
  localparam int CFG_BOOT_SEL_LSB = 0;
  localparam int CFG_PIN_CFG_LSB = 4;
  localparam int CFG_ROM_BOOT_BIT = 8;
  localparam logic [31:0] BOOT_CFG_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    phase_hold,
    phase_capture,
    phase_fetch,
    phase_run
  } phase_e;

  typedef struct packed {
    logic [1:0] boot_select;
    logic [3:0] pin_config;
  } strap_s;

  typedef struct packed {
    logic [6:0] setup;
    logic [6:0] strobe;
    logic [6:0] hold;
  } wait_timing_s;

  localparam wait_timing_s WAIT_RESET = '{WAIT_SETUP_RESET, WAIT_STROBE_RESET, WAIT_HOLD_RESET};
  localparam strap_s STRAP_RESET = '{BOOT_SEL_PULL_DEFAULT, PIN_CFG_PULL_DEFAULT};

endpackage

// ### verilog/boot_strap_reset_config.sv
// Operation
// [RULE_01] Sample boot select on pins 13:12 and pin config on 11:8 at reset.
// [RULE_02] After capture the shared pins return to async memory use automatically.
// [RULE_03] Boot select 00, 10, 11 forces first fetch to jump to ROM start.
// [RULE_04] Boot select 01 forces first fetch to jump to async memory start.
// [RULE_05] Async boot keeps reset-default timings until software reprograms them.
// [RULE_06] Enabled async interface resets timing to 16 setup, 64 strobe, 8 hold.
// [RULE_07] Latched boot select is readable in the boot configuration register.
// [RULE_08] Async interface enabled for 00, 01, 11; sync reset for 10.
// [RULE_09] Card interface 0 enabled only for boot select 10.
// [RULE_10] UART 0 enabled only for boot select 11.
// [RULE_11] SPI 0 enabled except for boot select 01.
// [RULE_12] Timer 0 always enabled; all module power domains default on.
// [RULE_13] Latched pin config bits set async pin arrangement right after reset.
// [RULE_14] Board places the async boot flash on the first chip select.
// [RULE_15] No direct execution from NAND; NAND boot goes via the ROM loader.
// [RULE_16] Fixed-default modules take their table states whatever the boot select.
`timescale 1ns/1ps
module boot_strap_reset_config
  import boot_strap_pkg::*;
#(
  parameter logic [31:0] JUMP_TEMPLATE = 32'h5500_0000
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Shared async address pins, strap phase
  input wire logic [STRAP_PIN_WIDTH-1:0] async_address_pins,
  output logic async_pin_function,
  output logic [3:0] async_pin_arrangement,
  // Processor core
  output logic core_reset_hold,
  input wire logic fetch_valid,
  output logic fetch_override,
  output logic [31:0] fetch_override_word,
  output logic [31:0] boot_vector,
  // Latched configuration
  output logic [1:0] boot_select,
  output logic [3:0] async_pin_config_strap,
  output logic [31:0] boot_config_reg,
  output logic rom_boot,
  output logic direct_async_exec,
  output logic async_chip_select_0_boot,
  // Module power controller
  output logic [NUM_MODULES-1:0] module_enable,
  output logic [NUM_MODULES-1:0] sync_reset_state,
  output logic [NUM_MODULES-1:0] power_domain_on,
  // Async interface wait states
  input wire logic timing_write,
  input wire wait_timing_s timing_in,
  output wait_timing_s async_timing
);

  typedef struct packed {
    phase_e phase;
    strap_s straps;
    wait_timing_s timing;
    logic pin_strap_mode;
    logic first_fetch_done;
    logic [31:0] override_word;
    logic [31:0] vector;
    logic [31:0] boot_config;
    logic [NUM_MODULES-1:0] enable;
    logic [NUM_MODULES-1:0] sync_reset;
    logic [NUM_MODULES-1:0] power_on;
  } state_s;

  state_s state;
  state_s next_state;
  logic [NUM_MODULES-1:0] table_enable;
  logic [NUM_MODULES-1:0] table_present;
  strap_s sampled;

  // Absolute jump: template in the top byte, word address below
  function automatic logic [31:0] make_jump(input logic [31:0] target);
    logic [31:0] word;
    word = JUMP_TEMPLATE;
    word[23:0] = target[25:2];
    return word;
  endfunction

  function automatic logic [31:0] vector_for(input logic [1:0] sel);
    logic [31:0] addr;
    addr = ROM_START_ADDR;
    // [RULE_04] Async memory vector
    if (sel == BOOT_ASYNC_MEM)
    begin
      addr = ASYNC_START_ADDR;
    end
    return addr;
  endfunction

  // [RULE_01] Strap fields on the address pins
  assign sampled.boot_select = async_address_pins[BOOT_SEL_LSB +: 2];
  assign sampled.pin_config = async_address_pins[PIN_CFG_LSB +: 4];

  // Table is decoded from the latched straps, never the live pins
  module_state_table u_table (
    .boot_select(state.straps.boot_select),
    .module_enable(table_enable),
    .module_present(table_present)
  );

  always_comb
  begin
    next_state = state;
    case (state.phase)
      phase_hold:
      begin
        next_state.phase = phase_capture;
      end
      phase_capture:
      begin
        // [RULE_01] Latch straps once after release
        next_state.straps = sampled;
        // [RULE_02] Hand pins back to memory use
        next_state.pin_strap_mode = 1'b0;
        // [RULE_07] Boot select into config word
        next_state.boot_config = BOOT_CFG_RESET;
        next_state.boot_config[CFG_BOOT_SEL_LSB +: 2] = sampled.boot_select;
        next_state.boot_config[CFG_PIN_CFG_LSB +: 4] = sampled.pin_config;
        next_state.boot_config[CFG_ROM_BOOT_BIT] = (sampled.boot_select != BOOT_ASYNC_MEM);
        // [RULE_03] Forced jump word
        next_state.vector = vector_for(sampled.boot_select);
        next_state.override_word = make_jump(vector_for(sampled.boot_select));
        next_state.phase = phase_fetch;
      end
      phase_fetch:
      begin
        // Module states load one cycle after the straps settle in the table
        next_state.enable = table_enable & table_present;
        next_state.sync_reset = ~table_enable & table_present;
        // [RULE_12] Power domains default on
        next_state.power_on = table_present;
        // [RULE_06] Slowest timing when interface enabled
        if (table_enable[MOD_ASYNC_IF])
        begin
          next_state.timing = WAIT_RESET;
        end
        next_state.phase = phase_run;
      end
      phase_run:
      begin
        // [RULE_03] First fetch takes the forced jump
        if (fetch_valid && !state.first_fetch_done)
        begin
          next_state.first_fetch_done = 1'b1;
        end
        // [RULE_05] Defaults hold until software writes
        if (timing_write && state.enable[MOD_ASYNC_IF])
        begin
          next_state.timing = timing_in;
        end
      end
      default:
      begin
        next_state.phase = phase_hold;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state.phase <= phase_hold;
      state.straps <= STRAP_RESET;
      state.timing <= WAIT_RESET;
      state.pin_strap_mode <= 1'b1;
      state.first_fetch_done <= 1'b0;
      state.override_word <= '0;
      state.vector <= '0;
      state.boot_config <= BOOT_CFG_RESET;
      state.enable <= '0;
      state.sync_reset <= '1;
      state.power_on <= '1;
    end
    else
    begin
      state <= next_state;
    end
  end

  // [RULE_02] Pins act as memory pins once straps are held
  assign async_pin_function = !state.pin_strap_mode;
  // [RULE_13] Latched pin config drives pin arrangement
  assign async_pin_arrangement = state.straps.pin_config;

  // Core stays in reset until the vector and module states are ready
  assign core_reset_hold = (state.phase != phase_run);
  assign fetch_override = (state.phase == phase_run) && !state.first_fetch_done;
  assign fetch_override_word = state.override_word;
  assign boot_vector = state.vector;

  assign boot_select = state.straps.boot_select;
  assign async_pin_config_strap = state.straps.pin_config;
  assign boot_config_reg = state.boot_config;
  // [RULE_15] Only async boot executes in place; NAND goes through ROM
  assign rom_boot = state.boot_config[CFG_ROM_BOOT_BIT];
  assign direct_async_exec = (state.phase == phase_run) && !state.boot_config[CFG_ROM_BOOT_BIT];
  // [RULE_14] Async boot fetches via the first chip select
  assign async_chip_select_0_boot = direct_async_exec;

  assign module_enable = state.enable;
  assign sync_reset_state = state.sync_reset;
  assign power_domain_on = state.power_on;
  assign async_timing = state.timing;

endmodule

// ### verilog/module_state_table.sv
`timescale 1ns/1ps
module module_state_table
  import boot_strap_pkg::*;
(
  // Latched boot select
  input wire logic [1:0] boot_select,
  // Per-module default state
  output logic [NUM_MODULES-1:0] module_enable,
  output logic [NUM_MODULES-1:0] module_present
);

  always_comb
  begin
    module_enable = '0;
    module_present = '1;
    module_present[MOD_RESERVED_A] = 1'b0;
    module_present[MOD_RESERVED_B] = 1'b0;
    // [RULE_16] Fixed enabled slots
    for (int i = MOD_FIXED_ON_LO; i <= MOD_FIXED_ON_HI; i++)
    begin
      module_enable[i] = 1'b1;
    end
    // Transfer engines follow the async interface
    module_enable[MOD_EDMA_CC] = (boot_select != BOOT_ROM_CARD);
    module_enable[MOD_EDMA_TC0] = (boot_select != BOOT_ROM_CARD);
    module_enable[MOD_EDMA_TC1] = (boot_select != BOOT_ROM_CARD);
    // [RULE_08] Async interface enable
    module_enable[MOD_ASYNC_IF] = (boot_select != BOOT_ROM_CARD);
    // [RULE_09] Card interface enable
    module_enable[MOD_CARD_IF_0] = (boot_select == BOOT_ROM_CARD);
    // [RULE_10] UART enable
    module_enable[MOD_UART_0] = (boot_select == BOOT_ROM_UART);
    // [RULE_11] SPI enable
    module_enable[MOD_SPI_0] = (boot_select != BOOT_ASYNC_MEM);
    // [RULE_12] Timer always enabled
    module_enable[MOD_TIMER_0] = 1'b1;
  end

endmodule
